/* File: guard_cpu_model.sv */
`timescale 1ns/1ps

module guard_cpu_model (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Interrupt side
   input  wire logic guard_overflow_irq,
   input  wire logic hold_service,
   output logic      nmi_accept,
   output logic      nmi_in_service,
   // Reset pin
   input  wire logic reset_pin_out,
   input  wire logic reset_pin_oe_n,
   output logic      reset_pin_in
);
   // ----------------------------------------
   // Pin and interrupt acceptance
   // ----------------------------------------
   logic [1:0] svc;

   assign reset_pin_in = reset_pin_oe_n ? 1'h1 : reset_pin_out;
   assign nmi_in_service = hold_service | (svc != 2'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_accept <= 1'h0;
         svc        <= 2'h0;
      end else begin
         nmi_accept <= guard_overflow_irq & !nmi_in_service & !nmi_accept;
         svc        <= nmi_accept ? 2'h2 : ((svc != 2'h0) ? svc - 2'h1 : 2'h0);
      end
   end
endmodule

/* File: guard_params.svh */
`ifndef GUARD_PARAMS_SVH
`define GUARD_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CODE      8'h04
`define OFS_STATUS    8'h08
`define OFS_IRQ_EN    8'h0C
`define OFS_IRQ_CLR   8'h10
`define OFS_STATE     8'h14
`define OFS_COUNT     8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_EN_BIT   3
`define CTRL_ACT_BIT  2
`define CTRL_DT_MSB   1
`define CTRL_DT_LSB   0
`define CTRL_RESET    4'hC
`define EVT_OVF_BIT   0
`define EVT_RST_BIT   1

// ----------------------------------------
// Codes for the code register
// ----------------------------------------
`define CODE_CLEAR    8'h4E
`define CODE_DISABLE  8'hB1

// ----------------------------------------
// Timing
// ----------------------------------------
`define HCLK_NS       5
`define HF_CLOCK_NS   125
`define RSTOUT_HF_CLKS 16
`define RSTOUT_CYC    ((`RSTOUT_HF_CLKS * `HF_CLOCK_NS + `HCLK_NS - 1) / `HCLK_NS)

`endif

/* File: guard_pkg.sv */
package guard_pkg;

   typedef enum logic [1:0] {
      ST_RUN    = 2'b00,
      ST_OFF    = 2'b01,
      ST_RSTOUT = 2'b10
   } guard_state_t;

   typedef struct packed {
      logic       en;
      logic       act;
      logic [1:0] dtime;
   } ctrl_t;

   typedef struct packed {
      logic stop;
      logic warmup;
      logic idle;
      logic slow;
   } power_t;

   typedef struct packed {
      logic rst_out;
      logic ovf;
   } evt_t;

endpackage

/* File: malfunction_guard_timer.sv */
// Contract
// RL1: action defaults reset, changeable once per reset
// RL2: usable as fixed-interval interrupt timer
// RL3: output fires on counter overflow unless cleared
// RL4: select 1 pulls reset pin low
// RL5: select 0 raises guard interrupt
// RL6: counter holds during stop, warm-up, idle
// RL7: enable bit set by reset; 1 enables
// RL8: disable: clear enable, then disable code
// RL9: code before clearing enable never disables
// RL10: disabling clears the counter
// RL11: clear code zeroes the counter
// RL12: two-bit field picks four quartered periods
// RL13: software clears counter within detection time
// RL14: guard interrupt ignores interrupt enables
// RL15: pending while prior interrupt in service
// RL16: reset pin low 8 to 24 fast clocks
// RL17: reset in slow mode starts oscillator
// RL18: other codes change nothing
// RL19: lock flag set by first control write
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "guard_params.svh"

module malfunction_guard_timer #(
   parameter int CNT_W = 22
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Count source and power modes
   input  wire logic              prescale_tick,
   input  wire guard_pkg::power_t power_mode,
   // Pseudo non-maskable interrupt
   input  wire logic              nmi_accept,
   input  wire logic              nmi_in_service,
   output logic                   guard_overflow_irq,
   // Maskable event interrupt
   output logic                   irq,
   // Open-drain reset pin
   input  wire logic              reset_pin_in,
   output logic                   reset_pin_out,
   output logic                   reset_pin_oe_n,
   // Oscillator request
   output logic                   hf_osc_on
);

   localparam int RST_CYC = `RSTOUT_CYC;
   localparam logic [8:0] RST_LAST = 9'(RST_CYC - 1);

   if (CNT_W < 7 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie in 7..32");
   end
   if (RST_CYC < 1 || RST_CYC > 512) begin : g_bad_rst
      $error("reset pulse count out of range");
   end

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic       wr_pend;
   logic       next_wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic       rd_wait;
   logic       next_rd_wait;
   logic [7:0] rd_addr;
   logic [7:0] next_rd_addr;
   logic       acc;

   assign acc = hsel & hready & htrans[1];

   always_comb begin
      next_wr_pend = acc & hwrite;
      next_rd_wait = acc & ~hwrite;
      next_wr_addr = acc ? haddr[7:0] : wr_addr;
      next_rd_addr = acc ? haddr[7:0] : rd_addr;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_wait <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else begin
         wr_pend <= next_wr_pend;
         rd_wait <= next_rd_wait;
         wr_addr <= next_wr_addr;
         rd_addr <= next_rd_addr;
      end
   end

   // One wait state on reads so a write just before is visible
   assign hreadyout = ~rd_wait;
   assign hresp     = 1'b0;

   logic wr_ctrl;
   logic wr_code;
   logic wr_irq_en;
   logic wr_irq_clr;
   assign wr_ctrl    = wr_pend && (wr_addr == `OFS_CTRL);
   assign wr_code    = wr_pend && (wr_addr == `OFS_CODE);
   assign wr_irq_en  = wr_pend && (wr_addr == `OFS_IRQ_EN);
   assign wr_irq_clr = wr_pend && (wr_addr == `OFS_IRQ_CLR);

   // ----------------------------------------
   // Guard core
   // ----------------------------------------
   guard_pkg::guard_state_t state;
   guard_pkg::guard_state_t next_state;
   guard_pkg::ctrl_t        ctrl;
   guard_pkg::ctrl_t        next_ctrl;
   logic                    lock;
   logic                    next_lock;
   logic [CNT_W-1:0]        cnt;
   logic [CNT_W-1:0]        next_cnt;
   logic [CNT_W-1:0]        mask;
   logic [8:0]              rst_cnt;
   logic [8:0]              next_rst_cnt;
   logic                    osc_on;
   logic                    next_osc_on;
   logic                    paused;
   logic                    run_tick;
   logic                    ovf;
   logic                    rst_fire;
   logic                    bus_ok;
   logic                    clr_cmd;
   logic                    dis_cmd;

   // RL6: pause in low power
   assign paused   = power_mode.stop | power_mode.warmup | power_mode.idle;
   assign run_tick = prescale_tick & ~paused;
   // RL12: quartered periods
   assign mask     = {CNT_W{1'b1}} >> {ctrl.dtime, 1'b0};
   // RL3: overflow detect
   assign ovf      = (state == guard_pkg::ST_RUN) && run_tick && (&(cnt | ~mask));
   // RL4: reset action
   assign rst_fire = ovf && ctrl.act;
   assign bus_ok   = (state != guard_pkg::ST_RSTOUT) && !rst_fire;
   // RL11 RL18: decoded codes only
   assign clr_cmd  = wr_code && (hwdata[7:0] == `CODE_CLEAR);
   // RL8 RL9: two-step disable
   assign dis_cmd  = wr_code && (hwdata[7:0] == `CODE_DISABLE) && !ctrl.en;

   always_comb begin
      next_state   = state;
      next_ctrl    = ctrl;
      next_lock    = lock;
      next_cnt     = cnt;
      next_rst_cnt = 9'h000;
      next_osc_on  = 1'b0;
      unique case (state)
         guard_pkg::ST_RUN: begin
            if (run_tick) begin
               next_cnt = CNT_W'(cnt + 1'b1);
            end
            if (rst_fire) begin
               next_state  = guard_pkg::ST_RSTOUT;
               next_cnt    = '0;
               // RL17: oscillator start
               next_osc_on = power_mode.slow;
            end
         end
         guard_pkg::ST_OFF: begin
            next_cnt = '0;
         end
         guard_pkg::ST_RSTOUT: begin
            next_rst_cnt = 9'(rst_cnt + 1'b1);
            next_osc_on  = osc_on;
            // RL16: pulse length
            if (rst_cnt == RST_LAST) begin
               next_state   = guard_pkg::ST_RUN;
               next_ctrl    = `CTRL_RESET;
               next_lock    = 1'b0;
               next_rst_cnt = 9'h000;
               next_osc_on  = 1'b0;
            end
         end
         default: begin
            next_state = guard_pkg::ST_RUN;
         end
      endcase
      if (bus_ok) begin
         if (wr_ctrl) begin
            next_ctrl.en    = hwdata[`CTRL_EN_BIT];
            next_ctrl.dtime = hwdata[`CTRL_DT_MSB:`CTRL_DT_LSB];
            // RL1: select once
            if (!lock) begin
               next_ctrl.act = hwdata[`CTRL_ACT_BIT];
            end
            // RL19: lock on write
            next_lock = 1'b1;
            // RL7: write enables
            if (hwdata[`CTRL_EN_BIT]) begin
               next_state = guard_pkg::ST_RUN;
            end
         end
         // RL11: counter restart
         if (clr_cmd) begin
            next_cnt = '0;
         end
         // RL10: clear on disable
         if (dis_cmd) begin
            next_state = guard_pkg::ST_OFF;
            next_cnt   = '0;
         end
      end
   end

   // RL7: enabled from reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state   <= guard_pkg::ST_RUN;
         ctrl    <= `CTRL_RESET;
         lock    <= 1'b0;
         cnt     <= '0;
         rst_cnt <= 9'h000;
         osc_on  <= 1'b0;
      end else begin
         state   <= next_state;
         ctrl    <= next_ctrl;
         lock    <= next_lock;
         cnt     <= next_cnt;
         rst_cnt <= next_rst_cnt;
         osc_on  <= next_osc_on;
      end
   end

   assign reset_pin_out  = 1'b0;
   assign reset_pin_oe_n = (state != guard_pkg::ST_RSTOUT);
   assign hf_osc_on      = osc_on;

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   guard_pkg::evt_t sts;
   guard_pkg::evt_t next_sts;
   guard_pkg::evt_t irq_en;
   guard_pkg::evt_t next_irq_en;
   guard_pkg::evt_t evt;
   logic            nmi_pend;
   logic            next_nmi_pend;
   logic            next_irq;

   always_comb begin
      evt.ovf     = ovf;
      evt.rst_out = rst_fire;
      next_irq_en = irq_en;
      if (wr_irq_en) begin
         next_irq_en = hwdata[1:0];
      end
      // RL2: interval events
      next_sts = sts & ~(wr_irq_clr ? guard_pkg::evt_t'(hwdata[1:0]) : 2'b00);
      next_sts = next_sts | evt;
      next_irq = |(next_sts & next_irq_en);
      // RL5: interrupt action
      next_nmi_pend = (nmi_pend & ~nmi_accept) | (ovf & ~ctrl.act);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sts      <= 2'b00;
         irq_en   <= 2'b00;
         irq      <= 1'b0;
         nmi_pend <= 1'b0;
      end else begin
         sts      <= next_sts;
         irq_en   <= next_irq_en;
         irq      <= next_irq;
         nmi_pend <= next_nmi_pend;
      end
   end

   // RL14: unmasked request
   // RL15: wait for return
   assign guard_overflow_irq = nmi_pend & ~nmi_in_service;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] next_hrdata;

   always_comb begin
      next_hrdata = hrdata;
      if (rd_wait) begin
         unique case (rd_addr)
            `OFS_CTRL:   next_hrdata = {28'h0000000, ctrl};
            `OFS_STATUS: next_hrdata = {30'h0, sts};
            `OFS_IRQ_EN: next_hrdata = {30'h0, irq_en};
            `OFS_STATE:  next_hrdata = {28'h0000000, nmi_pend, reset_pin_in, lock,
                                        state == guard_pkg::ST_RUN};
            `OFS_COUNT:  next_hrdata = 32'(cnt);
            default:     next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_lock_hold;
      lock && bus_ok |=> ctrl.act == $past(ctrl.act);
   endproperty
   a_lock_hold: assert property (p_lock_hold) // RL1
      else $error("action select changed after lock");

   property p_rst_out;
      rst_fire |=> (!reset_pin_oe_n && cnt == '0) [*8];
   endproperty
   a_rst_out: assert property (p_rst_out) // RL4
      else $error("reset pin not driven after overflow");

   property p_nmi_raise;
      ovf && !ctrl.act && !dis_cmd |=> nmi_pend && state == guard_pkg::ST_RUN;
   endproperty
   a_nmi_raise: assert property (p_nmi_raise) // RL5
      else $error("interrupt not raised on overflow");

   property p_pause;
      state == guard_pkg::ST_RUN && paused && !wr_code && !wr_ctrl |=> $stable(cnt);
   endproperty
   a_pause: assert property (p_pause) // RL6
      else $error("counter moved while paused");

   property p_disable;
      bus_ok && dis_cmd |=> state == guard_pkg::ST_OFF ##1 cnt == '0;
   endproperty
   a_disable: assert property (p_disable) // RL8
      else $error("disable sequence did not stop the guard");

   property p_no_early_dis;
      wr_code && hwdata[7:0] == `CODE_DISABLE && ctrl.en && state == guard_pkg::ST_RUN
         |=> state != guard_pkg::ST_OFF;
   endproperty
   a_no_early_dis: assert property (p_no_early_dis) // RL9
      else $error("guard disabled while enable was set");

   property p_clear;
      bus_ok && clr_cmd |=> cnt == '0;
   endproperty
   a_clear: assert property (p_clear) // RL11
      else $error("clear code did not zero the counter");

   property p_rst_len;
      state == guard_pkg::ST_RSTOUT && rst_cnt == RST_LAST |=> state == guard_pkg::ST_RUN
         && ctrl == `CTRL_RESET && !lock;
   endproperty
   a_rst_len: assert property (p_rst_len) // RL16
      else $error("reset pulse length wrong");

   property p_osc;
      rst_fire && power_mode.slow |=> hf_osc_on [*4];
   endproperty
   a_osc: assert property (p_osc) // RL17
      else $error("oscillator not started by slow-mode reset");

   property p_other_code;
      wr_code && hwdata[7:0] != `CODE_CLEAR && hwdata[7:0] != `CODE_DISABLE && bus_ok
         && !paused && !prescale_tick |=> $stable(cnt) && $stable(state);
   endproperty
   a_other_code: assert property (p_other_code) // RL18
      else $error("stray code altered the guard");

   property p_nmi_wait;
      nmi_in_service && nmi_pend && !nmi_accept |-> !guard_overflow_irq ##1 nmi_pend;
   endproperty
   a_nmi_wait: assert property (p_nmi_wait) // RL15
      else $error("guard interrupt raised during service");

   c_rst_fire: cover property (rst_fire ##[1:500] state == guard_pkg::ST_RUN);
   c_dis_seq:  cover property (wr_ctrl && !hwdata[`CTRL_EN_BIT] ##[1:20] dis_cmd);
   c_nmi:      cover property (ovf && !ctrl.act ##[1:20] nmi_accept);

endmodule

/* File: malfunction_guard_timer_test.sv */
`timescale 1ns/1ps
`include "guard_params.svh"

module malfunction_guard_timer_test;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
   localparam row_t table_rows [11] = '{
      '{1'h0, 8'h00, 32'hC},
      '{1'h0, 8'h14, 32'h5},
      '{1'h0, 8'h1C, 32'h0},
      '{1'h1, 8'h0C, 32'h3},
      '{1'h0, 8'h0C, 32'h3},
      '{1'h1, 8'h08, 32'hFF},
      '{1'h0, 8'h08, 32'h0},
      '{1'h1, 8'h00, 32'h8},
      '{1'h1, 8'h00, 32'hC},
      '{1'h0, 8'h00, 32'h8},
      '{1'h0, 8'h14, 32'h7}
   };
   logic              hclk, hresetn, hsel, hwrite, prescale_tick, hold_service;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   guard_pkg::power_t power_mode;
   logic              hreadyout, hresp, nmi_accept, nmi_in_service, guard_overflow_irq, irq;
   logic              reset_pin_in, reset_pin_out, reset_pin_oe_n, hf_osc_on;
   int                err_total, n_checks, n, m;

   malfunction_guard_timer #(.CNT_W(7)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .prescale_tick(prescale_tick), .power_mode(power_mode), .nmi_accept(nmi_accept),
      .nmi_in_service(nmi_in_service), .guard_overflow_irq(guard_overflow_irq), .irq(irq),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
      .reset_pin_oe_n(reset_pin_oe_n), .hf_osc_on(hf_osc_on));

   guard_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .guard_overflow_irq(guard_overflow_irq),
      .hold_service(hold_service), .nmi_accept(nmi_accept), .nmi_in_service(nmi_in_service),
      .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
      .reset_pin_in(reset_pin_in));

   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic pick(input int w);
      return (w == 0) ? guard_overflow_irq : ((w == 1) ? reset_pin_oe_n : hreadyout);
   endfunction

   // Counts extra falling edges until the level shows
   task wait_for(input int w, input logic lvl, output int c);
      c = 0;
      @(negedge hclk);
      while (pick(w) !== lvl) begin
         @(negedge hclk);
         c++;
         if (c > 3000) begin
            err_total++;
            conclude;
         end
      end
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_for(2, 1'h1, n);
      @(posedge hclk);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_for(2, 1'h1, n);
      rd = hrdata;
      @(posedge hclk);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      prescale_tick = 1'h0;
      power_mode = 4'h0;
      hold_service = 1'h0;
      err_total = 0;
      n_checks = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      foreach (table_rows[i]) begin
         bus(table_rows[i].wr, table_rows[i].a, table_rows[i].d);
         if (!table_rows[i].wr) chk("table read", table_rows[i].d, rd);
      end
      chk("hresp okay", 32'h0, 32'(hresp));
      // Interval mode, events unmasked only at the guard interrupt
      bus(1'h1, 8'h0C, 32'h0);
      prescale_tick <= 1'h1;
      for (int dt = 2; dt >= 0; dt--) begin
         bus(1'h1, 8'h00, {28'h0, 2'h2, dt[1:0]});
         wait_for(0, 1'h1, n);
         wait_for(0, 1'h0, n);
         wait_for(0, 1'h1, n);
         wait_for(0, 1'h0, n);
         wait_for(0, 1'h1, m);
         chk("irq period", 32'(1 << (7 - 2 * dt)), 32'(n + m + 2));
      end
      hold_service <= 1'h1;
      m = 0;
      rd = 32'h0;
      while (rd[3] !== 1'h1 && m < 100) begin
         bus(1'h0, 8'h14, 32'h0);
         m++;
      end
      chk("pending seen", 32'h8, rd & 32'h8);
      @(negedge hclk);
      chk("irq held in service", 32'h0, 32'(guard_overflow_irq));
      hold_service <= 1'h0;
      wait_for(0, 1'h1, n);
      chk("irq after service", 32'h1, 32'(guard_overflow_irq));
      bus(1'h0, 8'h08, 32'h0);
      chk("overflow event", 32'h1, rd & 32'h1);
      chk("irq masked", 32'h0, 32'(irq));
      bus(1'h1, 8'h0C, 32'h1);
      repeat (2) @(negedge hclk);
      chk("irq enabled", 32'h1, 32'(irq));
      bus(1'h1, 8'h00, 32'h0);
      bus(1'h1, 8'h04, 32'hB1);
      bus(1'h0, 8'h18, 32'h0);
      chk("count cleared on disable", 32'h0, rd);
      bus(1'h0, 8'h14, 32'h0);
      chk("disabled", 32'h0, rd & 32'h1);
      bus(1'h1, 8'h10, 32'h3);
      bus(1'h0, 8'h08, 32'h0);
      chk("status cleared", 32'h0, rd);
      repeat (2) @(negedge hclk);
      chk("irq cleared", 32'h0, 32'(irq));
      // Reversed disable order leaves it running
      bus(1'h1, 8'h00, 32'h8);
      bus(1'h1, 8'h04, 32'hB1);
      bus(1'h1, 8'h00, 32'h0);
      bus(1'h0, 8'h14, 32'h0);
      chk("still running", 32'h1, rd & 32'h1);
      prescale_tick <= 1'h0;
      bus(1'h0, 8'h18, 32'h0);
      m = int'(rd);
      bus(1'h1, 8'h04, 32'h55);
      bus(1'h0, 8'h18, 32'h0);
      chk("other code", 32'(m), rd);
      bus(1'h1, 8'h04, 32'h4E);
      bus(1'h0, 8'h18, 32'h0);
      chk("clear code", 32'h0, rd);
      prescale_tick <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         power_mode <= 4'h8 >> i;
         bus(1'h0, 8'h18, 32'h0);
         m = int'(rd);
         repeat (20) @(posedge hclk);
         bus(1'h0, 8'h18, 32'h0);
         chk("count held", 32'(m), rd);
      end
      // Mid-run reset, then reset action in slow mode
      hresetn <= 1'h0;
      power_mode <= 4'h1;
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      bus(1'h1, 8'h00, 32'hF);
      wait_for(1, 1'h0, n);
      chk("osc on", 32'h1, 32'(hf_osc_on));
      chk("pin low", 32'h0, 32'(reset_pin_in));
      chk("no guard irq", 32'h0, 32'(guard_overflow_irq));
      wait_for(1, 1'h1, n);
      chk("pulse length", 32'(`RSTOUT_CYC), 32'(n + 1));
      bus(1'h0, 8'h00, 32'h0);
      chk("ctrl after pulse", 32'hC, rd);
      bus(1'h0, 8'h08, 32'h0);
      chk("reset event", 32'h2, rd & 32'h2);
      conclude;
   end
endmodule
